// ### hw/fqtu_defines.svh
// constants of the flash query / temporary unprotect host controller
// assumes a 50 MHz clock and a flash part wired to the pins of fqtu_host
//
// Operation
// - unprotect lasts only while the reset pin is held at the elevated voltage
// - query entry is 98h written to word address 55h or byte address AAh
// - in word mode address bits A7 and up are zero during query reads
// - from array read, query mode ends only on the reset command
`ifndef FQTU_DEFINES_SVH
`define FQTU_DEFINES_SVH

// ====================================================================
// commands and addresses
`define FQTU_QUERY_CMD 8'h98
`define FQTU_RESET_CMD 8'hf0
`define FQTU_QRY_ADDR_WORD 21'h000055
`define FQTU_QRY_ADDR_BYTE 21'h0000aa
`define FQTU_IX_FIRST 8'h10
`define FQTU_IX_LAST 8'h3c

// ====================================================================
// timing
`define FQTU_CLK_NS 20
`define FQTU_T_PHASE_NS 80
`define FQTU_PHASE_CYC ((`FQTU_T_PHASE_NS + `FQTU_CLK_NS - 1) / `FQTU_CLK_NS)

// ====================================================================
// query table, nonzero entries plus the zero default
`define FQTU_IX_SIG0 8'h10
`define FQTU_IX_SIG1 8'h11
`define FQTU_IX_SIG2 8'h12
`define FQTU_IX_PCMD 8'h13
`define FQTU_IX_PEXT 8'h15
`define FQTU_IX_VMIN 8'h1b
`define FQTU_IX_VMAX 8'h1c
`define FQTU_IX_TWR 8'h1f
`define FQTU_IX_TER 8'h21
`define FQTU_IX_MWR 8'h23
`define FQTU_IX_MER 8'h25
`define FQTU_IX_SIZE 8'h27
`define FQTU_IX_IFC 8'h28
`define FQTU_IX_NREG 8'h2c
`define FQTU_IX_R1C 8'h2f
`define FQTU_IX_R2A 8'h31
`define FQTU_IX_R2C 8'h33
`define FQTU_IX_R3C 8'h37
`define FQTU_IX_R4A 8'h39
`define FQTU_IX_R4D 8'h3c
`define FQTU_V_SIG0 16'h0051
`define FQTU_V_SIG1 16'h0052
`define FQTU_V_SIG2 16'h0059
`define FQTU_V_PCMD 16'h0002
`define FQTU_V_PEXT 16'h0040
`define FQTU_V_VMIN 16'h0027
`define FQTU_V_VMAX 16'h0036
`define FQTU_V_TWR 16'h0004
`define FQTU_V_TER 16'h000a
`define FQTU_V_MWR 16'h0005
`define FQTU_V_MER 16'h0004
`define FQTU_V_SIZE 16'h0015
`define FQTU_V_IFC 16'h0002
`define FQTU_V_NREG 16'h0004
`define FQTU_V_R1C 16'h0040
`define FQTU_V_R2A 16'h0001
`define FQTU_V_R2C 16'h0020
`define FQTU_V_R3C 16'h0080
`define FQTU_V_R4A 16'h001e
`define FQTU_V_R4D 16'h0001
`define FQTU_V_ZERO 16'h0000

`endif

// ### hw/fqtu_pkg.sv
// types of the flash query / temporary unprotect host controller
// assumes fqtu_defines.svh for all numbers
package fqtu_pkg;

    // ====================================================================
    // sequencer states
    typedef enum logic [3:0] {
        FQTU_S_IDLE = 4'b0001,
        FQTU_S_WR = 4'b0010,
        FQTU_S_WRH = 4'b0100,
        FQTU_S_RD = 4'b1000
    } fqtu_state_t;

    // ====================================================================
    // flash bus pins; addr bit 0 is A-1 in byte mode
    typedef struct packed {
        logic [20:0] addr;
        logic [15:0] dq;
        logic dq_oe;
        logic ce_n;
        logic oe_n;
        logic we_n;
    } fqtu_pins_t;

endpackage

// ### hw/fqtu_query_rom.sv
// expected query table contents by word index
// assumes index is a word address of the query table
`timescale 1ns/1ps
`include "fqtu_defines.svh"

module fqtu_query_rom import fqtu_pkg::*; (
    input wire logic [7:0] idx_in,
    output logic [15:0] exp_out
);
    // ====================================================================
    // lookup; all unlisted entries are zero
    always_comb begin
        exp_out = `FQTU_V_ZERO;
        case (idx_in)
            `FQTU_IX_SIG0: exp_out = `FQTU_V_SIG0;
            `FQTU_IX_SIG1: exp_out = `FQTU_V_SIG1;
            `FQTU_IX_SIG2: exp_out = `FQTU_V_SIG2;
            `FQTU_IX_PCMD: exp_out = `FQTU_V_PCMD;
            `FQTU_IX_PEXT: exp_out = `FQTU_V_PEXT;
            `FQTU_IX_VMIN: exp_out = `FQTU_V_VMIN;
            `FQTU_IX_VMAX: exp_out = `FQTU_V_VMAX;
            `FQTU_IX_TWR: exp_out = `FQTU_V_TWR;
            `FQTU_IX_TER: exp_out = `FQTU_V_TER;
            `FQTU_IX_MWR: exp_out = `FQTU_V_MWR;
            `FQTU_IX_MER: exp_out = `FQTU_V_MER;
            `FQTU_IX_SIZE: exp_out = `FQTU_V_SIZE;
            `FQTU_IX_IFC: exp_out = `FQTU_V_IFC;
            `FQTU_IX_NREG: exp_out = `FQTU_V_NREG;
            `FQTU_IX_R1C: exp_out = `FQTU_V_R1C;
            `FQTU_IX_R2A: exp_out = `FQTU_V_R2A;
            `FQTU_IX_R2C: exp_out = `FQTU_V_R2C;
            `FQTU_IX_R3C: exp_out = `FQTU_V_R3C;
            `FQTU_IX_R4A: exp_out = `FQTU_V_R4A;
            `FQTU_IX_R4D: exp_out = `FQTU_V_R4D;
            default: exp_out = `FQTU_V_ZERO;
        endcase
    end
endmodule // fqtu_query_rom

// ### hw/fqtu_host.sv
// host controller: reads and checks the flash query table, drives unprotect
// assumes flash pins are wired to pins_out/dq_in and dq_in is synchronous
`timescale 1ns/1ps
`include "fqtu_defines.svh"

module fqtu_host import fqtu_pkg::*; #(
    parameter int PHASE_CYC = `FQTU_PHASE_CYC,
    parameter logic [7:0] RESET_CMD = `FQTU_RESET_CMD
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic start_in,
    input wire logic autosel_in,
    input wire logic byte_mode_in,
    input wire logic unprotect_req_in,
    input wire logic [15:0] dq_in,
    output fqtu_pins_t pins_out,
    output logic byte_n_out,
    output logic rst_n_out,
    output logic elevated_id_voltage_out,
    output logic busy_out,
    output logic done_out,
    output logic rd_valid_out,
    output logic [7:0] rd_index_out,
    output logic [15:0] rd_data_out,
    output logic mismatch_out,
    output logic back_to_id_out
);
    // ====================================================================
    // state
    fqtu_state_t state_ff, nxt_state;
    logic [7:0] cnt_ff, nxt_cnt;
    logic [7:0] idx_ff, nxt_idx;
    logic exit_ff, nxt_exit;
    logic from_id_ff;
    fqtu_pins_t nxt_pins;

    // ====================================================================
    // decode
    wire logic ph_end = (cnt_ff == 8'(PHASE_CYC - 1));
    wire logic last_idx = (idx_ff == `FQTU_IX_LAST);
    wire logic idle_start = (state_ff == FQTU_S_IDLE) && start_in;
    wire logic rd_sample = (state_ff == FQTU_S_RD) && ph_end;
    wire logic wr_done = (state_ff == FQTU_S_WRH) && ph_end;
    // byte mode doubles the index; word mode keeps A7 and up at zero
    wire logic [20:0] rd_addr = byte_mode_in ? {12'h000, nxt_idx, 1'b0} : {13'h0000, nxt_idx};
    wire logic [20:0] entry_addr = byte_mode_in ? `FQTU_QRY_ADDR_BYTE : `FQTU_QRY_ADDR_WORD;
    wire logic [15:0] exp_word;
    wire logic [15:0] exp_cmp = byte_mode_in ? {8'h00, exp_word[7:0]} : exp_word;
    wire logic [15:0] rd_cmp = byte_mode_in ? {8'h00, dq_in[7:0]} : dq_in;
    wire logic mism_now = rd_sample && (exp_cmp != rd_cmp);

    fqtu_query_rom u_rom (
        .idx_in(idx_ff),
        .exp_out(exp_word)
    );

    // ====================================================================
    // sequencer: entry write, table reads, reset-command write
    always_comb begin
        nxt_state = state_ff;
        nxt_idx = idx_ff;
        nxt_exit = exit_ff;
        nxt_cnt = ph_end ? 8'h00 : cnt_ff + 8'h01;
        unique case (state_ff)
            FQTU_S_IDLE: begin
                nxt_cnt = 8'h00;
                if (start_in) begin
                    nxt_state = FQTU_S_WR;
                    nxt_exit = 1'b0;
                end
            end
            FQTU_S_WR: begin
                if (ph_end) begin
                    nxt_state = FQTU_S_WRH;
                end
            end
            FQTU_S_WRH: begin
                if (ph_end) begin
                    nxt_state = exit_ff ? FQTU_S_IDLE : FQTU_S_RD;
                    nxt_idx = `FQTU_IX_FIRST;
                end
            end
            FQTU_S_RD: begin
                // reads never leave query mode; only the reset write does
                if (ph_end && last_idx) begin
                    nxt_state = FQTU_S_WR;
                    nxt_exit = 1'b1;
                end else if (ph_end) begin
                    nxt_idx = idx_ff + 8'h01;
                end
            end
        endcase
    end

    // ====================================================================
    // pin levels for the coming state
    always_comb begin
        nxt_pins = '{addr: 21'h000000, dq: 16'h0000, dq_oe: 1'b0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
        unique case (nxt_state)
            FQTU_S_IDLE: nxt_pins.addr = 21'h000000;
            FQTU_S_WR, FQTU_S_WRH: begin
                // reset write address is a don't care, zero is used
                nxt_pins.addr = nxt_exit ? 21'h000000 : entry_addr;
                nxt_pins.dq = {8'h00, nxt_exit ? RESET_CMD : `FQTU_QUERY_CMD};
                nxt_pins.dq_oe = 1'b1;
                nxt_pins.ce_n = (nxt_state == FQTU_S_WRH);
                nxt_pins.we_n = (nxt_state == FQTU_S_WRH);
            end
            FQTU_S_RD: begin
                nxt_pins.addr = rd_addr;
                nxt_pins.ce_n = 1'b0;
                nxt_pins.oe_n = 1'b0;
            end
        endcase
    end

    // ====================================================================
    // registers
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            state_ff <= FQTU_S_IDLE;
            cnt_ff <= 8'h00;
            idx_ff <= 8'h00;
            exit_ff <= 1'b0;
            pins_out <= '{addr: 21'h000000, dq: 16'h0000, dq_oe: 1'b0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
            busy_out <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            idx_ff <= nxt_idx;
            exit_ff <= nxt_exit;
            pins_out <= nxt_pins;
            busy_out <= (nxt_state != FQTU_S_IDLE);
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            from_id_ff <= 1'b0;
            back_to_id_out <= 1'b0;
            done_out <= 1'b0;
            rd_valid_out <= 1'b0;
            rd_index_out <= 8'h00;
            rd_data_out <= 16'h0000;
            mismatch_out <= 1'b0;
        end else begin
            if (idle_start) begin
                from_id_ff <= autosel_in;
            end
            // reset write from autoselect lands back in autoselect
            if (idle_start) begin
                back_to_id_out <= 1'b0;
            end else if (wr_done && exit_ff) begin
                back_to_id_out <= from_id_ff;
            end
            done_out <= wr_done && exit_ff;
            rd_valid_out <= rd_sample;
            if (rd_sample) begin
                rd_index_out <= idx_ff;
                rd_data_out <= rd_cmp;
            end
            // a miss in the start cycle cannot occur; set still wins over clear
            mismatch_out <= mism_now || (mismatch_out && !idle_start);
        end
    end

    // reset pin held high; unprotect only follows the request level
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            elevated_id_voltage_out <= 1'b0;
            byte_n_out <= 1'b1;
            rst_n_out <= 1'b0;
        end else begin
            elevated_id_voltage_out <= unprotect_req_in;
            byte_n_out <= !byte_mode_in;
            rst_n_out <= 1'b1;
        end
    end

    // ====================================================================
    // checks
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    sequence s_entry_write;
        (state_ff == FQTU_S_WR) && !exit_ff;
    endsequence
    sequence s_exit_write;
        (state_ff == FQTU_S_WR) && exit_ff;
    endsequence

    property p_uv_follow;
        unprotect_req_in |=> elevated_id_voltage_out ##1 (elevated_id_voltage_out == $past(unprotect_req_in));
    endproperty
    a_uv_follow: assert property (p_uv_follow) else $error("unprotect level does not follow request");

    property p_uv_drop;
        !unprotect_req_in |=> !elevated_id_voltage_out;
    endproperty
    a_uv_drop: assert property (p_uv_drop) else $error("elevated voltage kept after request dropped");

    property p_entry_cmd;
        s_entry_write |-> pins_out.dq[7:0] == `FQTU_QUERY_CMD && !pins_out.we_n && pins_out.dq_oe
            && pins_out.addr == (byte_mode_in ? `FQTU_QRY_ADDR_BYTE : `FQTU_QRY_ADDR_WORD);
    endproperty
    a_entry_cmd: assert property (p_entry_cmd) else $error("bad query entry write");

    property p_start;
        (state_ff == FQTU_S_IDLE) && start_in |=> s_entry_write;
    endproperty
    a_start: assert property (p_start) else $error("start not taken from idle");

    property p_word_addr;
        (state_ff == FQTU_S_RD) && !byte_mode_in |-> pins_out.addr[20:7] == 14'h0000;
    endproperty
    a_word_addr: assert property (p_word_addr) else $error("upper address bits set in word read");

    property p_stay_query;
        (state_ff == FQTU_S_RD) && !last_idx |=> (state_ff == FQTU_S_RD);
    endproperty
    a_stay_query: assert property (p_stay_query) else $error("left table reads early");

    property p_exit_cmd;
        s_exit_write |-> pins_out.dq[7:0] == RESET_CMD && pins_out.addr == 21'h000000 && !pins_out.we_n;
    endproperty
    a_exit_cmd: assert property (p_exit_cmd) else $error("bad reset command write");

    property p_back_id;
        (state_ff == FQTU_S_WRH) && ph_end && exit_ff |=> done_out && (back_to_id_out == $past(from_id_ff));
    endproperty
    a_back_id: assert property (p_back_id) else $error("return mode not reported");

    property p_sig_check;
        rd_sample && idx_ff == `FQTU_IX_SIG0 && rd_cmp != `FQTU_V_SIG0 |=> mismatch_out && rd_valid_out;
    endproperty
    a_sig_check: assert property (p_sig_check) else $error("signature miss not flagged");

    property p_read_pace;
        (state_ff == FQTU_S_WRH) && ph_end && !exit_ff |-> ##[1:16] rd_valid_out;
    endproperty
    a_read_pace: assert property (p_read_pace) else $error("first read not sampled in time");
endmodule // fqtu_host

// ### tb/fqtu_flash_model.sv
// behavioural flash part: query table, mode tracking, temporary unprotect
// assumes pins come from fqtu_host; no clock, reacts to pin edges only
`timescale 1ns/1ps

module fqtu_flash_model import fqtu_pkg::*; #(
    parameter logic [7:0] RESET_CMD = 8'hf0
) (
    input wire fqtu_pins_t pins_in,
    input wire logic byte_n_in,
    input wire logic rst_n_in,
    input wire logic elev_in,
    input wire logic set_autosel_in,
    input wire logic corrupt_in,
    output logic [15:0] dq_out,
    output logic [1:0] mode_out,
    output logic unprot_out
);
    // ==========================================
    // query table
    function automatic logic [15:0] qry_val(input logic [7:0] ix);
        case (ix)
            8'h10: qry_val = 16'h0051;
            8'h11: qry_val = 16'h0052;
            8'h12: qry_val = 16'h0059;
            8'h13: qry_val = 16'h0002;
            8'h15: qry_val = 16'h0040;
            8'h1b: qry_val = 16'h0027;
            8'h1c: qry_val = 16'h0036;
            8'h1f: qry_val = 16'h0004;
            8'h21: qry_val = 16'h000a;
            8'h23: qry_val = 16'h0005;
            8'h25: qry_val = 16'h0004;
            8'h27: qry_val = 16'h0015;
            8'h28: qry_val = 16'h0002;
            8'h2c: qry_val = 16'h0004;
            8'h2f: qry_val = 16'h0040;
            8'h31: qry_val = 16'h0001;
            8'h33: qry_val = 16'h0020;
            8'h37: qry_val = 16'h0080;
            8'h39: qry_val = 16'h001e;
            8'h3c: qry_val = 16'h0001;
            default: qry_val = 16'h0000;
        endcase
    endfunction

    // ==========================================
    // command decode; modes 0 array, 1 autoselect, 2 query
    logic [1:0] mode_ff;
    logic [1:0] ret_ff;
    logic [15:0] raw;
    logic [15:0] rd_val;
    wire wr_end = pins_in.ce_n | pins_in.we_n;
    wire rd_end = pins_in.ce_n | pins_in.oe_n;
    wire [20:0] word_addr = byte_n_in ? pins_in.addr : {1'b0, pins_in.addr[20:1]};
    wire qry_hit = (pins_in.dq[7:0] == 8'h98) && (pins_in.addr == (byte_n_in ? 21'h000055 : 21'h0000aa));

    always @(posedge wr_end or negedge rst_n_in or posedge set_autosel_in) begin
        if (!rst_n_in) begin
            mode_ff <= 2'h0;
        end else if (set_autosel_in) begin
            mode_ff <= 2'h1;
        end else if (qry_hit && mode_ff != 2'h2) begin
            ret_ff <= mode_ff;
            mode_ff <= 2'h2;
        end else if (pins_in.dq[7:0] == RESET_CMD) begin
            mode_ff <= (mode_ff == 2'h2) ? ret_ff : 2'h0;
        end else begin
            mode_ff <= 2'h0;
        end
    end

    // ==========================================
    // read data; upper address bits set give garbage, not mercy
    always_comb begin
        if (mode_ff == 2'h2) begin
            raw = (word_addr[20:7] == 14'h0) ? (qry_val(word_addr[7:0]) ^ {15'h0, corrupt_in}) : 16'hdead;
        end else if (mode_ff == 2'h1) begin
            raw = 16'h00c3;
        end else begin
            raw = {word_addr[7:0], ~word_addr[7:0]};
        end
    end
    assign rd_val = byte_n_in ? raw : {~raw[7:0], raw[7:0]};
    // released bus shows the inverse so stale data cannot pass
    assign dq_out = rd_end ? ~rd_val : rd_val;
    assign mode_out = mode_ff;
    // protected sectors writable only while this holds
    assign unprot_out = rst_n_in & elev_in;

endmodule // fqtu_flash_model

// ### tb/tb_top.sv
// testbench of fqtu_host against the behavioural flash part
// assumes default PHASE_CYC of 4, so a pass takes 197 cycles
`timescale 1ns/1ps

module tb_top import fqtu_pkg::*; ;
    logic mclk_in = 1'b0;
    logic rst_in = 1'b1;
    logic start_in = 1'b0;
    logic autosel_in = 1'b0;
    logic byte_mode_in = 1'b0;
    logic unprotect_req_in = 1'b0;
    logic set_asel = 1'b0;
    logic corrupt = 1'b0;
    wire [15:0] dq;
    fqtu_pins_t pins;
    logic byte_n, rst_n, elev, busy, done, rd_valid, mism, back_id;
    logic [7:0] rd_index;
    logic [15:0] rd_data;
    wire [1:0] mode;
    wire unprot;
    int errors = 0;
    int num_checks = 0;
    int cyc_cnt = 0;

    always #10 mclk_in = ~mclk_in;

    fqtu_host i_fqtu_host (.mclk_in(mclk_in), .rst_in(rst_in), .start_in(start_in), .autosel_in(autosel_in),
        .byte_mode_in(byte_mode_in), .unprotect_req_in(unprotect_req_in), .dq_in(dq), .pins_out(pins),
        .byte_n_out(byte_n), .rst_n_out(rst_n), .elevated_id_voltage_out(elev), .busy_out(busy),
        .done_out(done), .rd_valid_out(rd_valid), .rd_index_out(rd_index), .rd_data_out(rd_data),
        .mismatch_out(mism), .back_to_id_out(back_id));

    fqtu_flash_model i_fqtu_flash_model (.pins_in(pins), .byte_n_in(byte_n), .rst_n_in(rst_n),
        .elev_in(elev), .set_autosel_in(set_asel), .corrupt_in(corrupt), .dq_out(dq), .mode_out(mode),
        .unprot_out(unprot));

    // ==========================================
    // checking and closing
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    always @(posedge mclk_in) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 4000) begin
            errors++;
            complete_run();
        end
    end

    // ==========================================
    // scenarios
    // one full pass; a stray start at cycle 60 must be ignored
    task automatic run_pass(input logic asel, input logic bmode, input logic bad);
        int cyc;
        int nrd;
        logic [15:0] exp;
        cyc = 0;
        nrd = 0;
        // let the previous done pulse drop before the loop tests it
        @(negedge mclk_in);
        autosel_in = asel;
        byte_mode_in = bmode;
        corrupt = bad;
        if (asel) begin
            set_asel = 1'b1;
            @(negedge mclk_in);
            set_asel = 1'b0;
        end
        start_in = 1'b1;
        while (done !== 1'b1 && cyc < 400) begin
            @(negedge mclk_in);
            cyc++;
            start_in = (cyc == 60);
            if (cyc == 1) chk(busy, 1);
            if (cyc == 1) chk(byte_n, !bmode);
            if (!pins.oe_n && !bmode) chk(pins.addr[20:7], 0);
            if (rd_valid) begin
                exp = i_fqtu_flash_model.qry_val(8'h10 + nrd[7:0]) ^ {15'h0, bad};
                if (bmode) exp[15:8] = 8'h00;
                chk(rd_index, 8'h10 + nrd[7:0]);
                chk(rd_data, exp);
                chk(mode, 2);
                nrd++;
            end
        end
        chk(cyc, 197);
        chk(nrd, 45);
        chk(busy, 0);
        chk(mism, bad);
        chk(back_id, asel);
        chk(mode, asel ? 1 : 0);
    endtask

    // reset between passes with the host idle; the low reset pin also returns the part to array reads
    task automatic run_reset();
        @(negedge mclk_in);
        rst_in = 1'b1;
        repeat (3) @(negedge mclk_in);
        chk(rst_n, 0);
        chk(pins.ce_n, 1);
        chk(busy, 0);
        chk(mode, 0);
        rst_in = 1'b0;
        @(negedge mclk_in);
        chk(rst_n, 1);
        chk(back_id, 0);
        chk(mism, 0);
    endtask

    task automatic run_unprotect();
        @(negedge mclk_in);
        unprotect_req_in = 1'b1;
        @(negedge mclk_in);
        chk(elev, 1);
        chk(unprot, 1);
        repeat (5) @(negedge mclk_in);
        chk(elev, 1);
        unprotect_req_in = 1'b0;
        @(negedge mclk_in);
        chk(elev, 0);
        chk(unprot, 0);
    endtask

    initial begin
        repeat (2) @(negedge mclk_in);
        chk(rst_n, 0);
        chk(pins.ce_n, 1);
        chk(elev, 0);
        @(negedge mclk_in);
        rst_in = 1'b0;
        @(negedge mclk_in);
        chk(rst_n, 1);
        run_pass(1'b0, 1'b0, 1'b0);
        run_pass(1'b0, 1'b1, 1'b0);
        run_pass(1'b1, 1'b0, 1'b0);
        run_pass(1'b1, 1'b1, 1'b0);
        // part is left in autoselect; a reset brings it back to array reads
        run_reset();
        run_pass(1'b0, 1'b0, 1'b1);
        // clean pass right after a failing one clears the sticky flag
        run_pass(1'b0, 1'b0, 1'b0);
        run_unprotect();
        complete_run();
    end

endmodule // tb_top
